//--- rtl/sspc3_pkg.sv
// Package: register map, field positions, modes and bus carriers.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package sspc3_pkg;

   // Register byte addresses
   localparam logic [7:0] ctrl_two_off   = 8'h00;
   localparam logic [7:0] ctrl_three_off = 8'h04;
   localparam logic [7:0] buf_off        = 8'h08;
   localparam logic [7:0] stat_off       = 8'h0C;
   localparam logic [7:0] mode_off       = 8'h10;

   // Control two fields
   localparam int ack_seq_bit  = 4;
   localparam int recv_bit     = 3;
   localparam int stop_bit     = 2;
   localparam int rstart_bit   = 1;
   localparam int start_bit    = 0;

   // Control three fields
   localparam int ack_time_bit = 7;
   localparam int overwr_bit   = 4;

   // Status fields
   localparam int full_bit     = 0;
   localparam int ovf_bit      = 1;
   localparam int idle_bit     = 2;

   // Reset values
   localparam logic [7:0] ctrl_three_rst = 8'h00;
   localparam logic [7:0] ctrl_two_rst   = 8'h00;

   // AXI responses
   localparam logic [1:0] resp_okay   = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   typedef enum logic [1:0] {
      mode_spi_master,
      mode_spi_slave,
      mode_i2c_master,
      mode_i2c_slave
   } port_mode_e;

   typedef struct packed {
      logic       awvalid;
      logic [7:0] awaddr;
      logic       wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic       bready;
      logic       arvalid;
      logic [7:0] araddr;
      logic       rready;
   } axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_s;

endpackage

//--- rtl/rx_buffer_ctl.sv
// Receive buffer update and overflow logic for the shift data buffer.
// Assumes byte-done strobes and clears arrive on the same clock.
`timescale 1ns/100ps
module rx_buffer_ctl
   import sspc3_pkg::*;
#(
   parameter int width = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Controls
   input  wire port_mode_e       mode,
   input  wire logic             overwrite_en,
   // Received byte
   input  wire logic             byte_done,
   input  wire logic [width-1:0] byte_in,
   // Software side
   input  wire logic             buf_read,
   input  wire logic             ovf_clear,
   input  wire logic             sw_load,
   input  wire logic [width-1:0] sw_data,
   // State
   output logic [width-1:0]      buf_data,
   output logic                  full,
   output logic                  ovf
);
   if (width < 1) begin
      $error("width must be positive");
   end

   typedef struct packed {
      logic [width-1:0] data;
      logic             full;
      logic             ovf;
   } st_s;

   st_s q, d;
   logic slave;
   logic take;
   logic lost;

   always_comb begin
      d = q;
      slave = (mode == mode_spi_slave) || (mode == mode_i2c_slave);
      // Masters ignore the overwrite enable
      take = byte_done && (!q.full || !slave ||
             (overwrite_en && mode == mode_spi_slave));
      lost = byte_done && q.full && !take;
      if (buf_read) d.full = 1'b0;
      if (ovf_clear) d.ovf = 1'b0;
      if (sw_load) d.data = sw_data;
      if (take) begin
         d.data = byte_in;
         d.full = 1'b1;
      end
      if (lost) begin
         d.ovf  = 1'b1;
         d.full = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign buf_data = q.data;
   assign full     = q.full;
   assign ovf      = q.ovf;
endmodule

//--- rtl/sync_serial_port_ctrl3.sv
// Control three slice of a synchronous serial port: sequence request
// gating while the bus engine is busy, and the buffer overwrite option.
// Assumes the engine reports idle and byte completion on this clock.
//
// Contract
// - Engine busy: refuse setting ack, receive, stop, restart, start bits.
// - Engine busy: software writes to the data buffer are ignored.
// - SPI slave, no overwrite, byte while full: set overflow, keep buffer.
// - In I2C or SPI master mode the overwrite enable has no effect.
`timescale 1ns/100ps
module sync_serial_port_ctrl3
   import sspc3_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register bus
   input  wire axil_req_s  axi_req,
   output axil_rsp_s       axi_rsp,
   // Engine side
   input  wire logic       engine_idle,
   input  wire logic       byte_done,
   input  wire logic [7:0] byte_in,
   input  wire logic       seq_done,
   // Outputs to the engine
   output logic [4:0]      seq_request,
   output logic            overwrite_en,
   output logic [1:0]      port_mode,
   output logic [7:0]      tx_data,
   output logic            tx_load
);
   typedef struct packed {
      axil_rsp_s   rsp;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic [7:0]  ctrl_two;
      logic [7:0]  ctrl_three;
      port_mode_e  mode;
      logic        tx_load;
      logic        idle_s;
   } st_s;

   st_s q, d;
   logic [7:0] buf_data;
   logic       full;
   logic       ovf;
   logic       buf_read;
   logic       ovf_clear;
   logic       sw_load;

   function automatic logic known(input logic [7:0] a);
      known = (a == ctrl_two_off) || (a == ctrl_three_off) ||
              (a == buf_off) || (a == stat_off) || (a == mode_off);
   endfunction

   // Register map must be word aligned
   if (ctrl_two_off[1:0] != 2'b00 || ctrl_three_off[1:0] != 2'b00 ||
       buf_off[1:0] != 2'b00 || stat_off[1:0] != 2'b00 ||
       mode_off[1:0] != 2'b00) begin
      $error("register offsets must be word aligned");
   end
   // Status fields must sit in the low byte
   if (full_bit > 7 || ovf_bit > 7 || idle_bit > 7) begin
      $error("status fields must sit in the low byte");
   end
   if (ack_time_bit != 7 || overwr_bit > 6) begin
      $error("control three fields out of range");
   end

   // Request bits hold their value while the engine is busy
   function automatic logic [7:0] ctrl_two_next(
      input logic [7:0] cur,
      input logic [7:0] val,
      input logic       idle
   );
      ctrl_two_next = idle ? val : {val[7:5], cur[4:0]};
   endfunction

   // Acknowledge-time status stays read-only
   function automatic logic [7:0] ctrl_three_next(
      input logic [7:0] cur,
      input logic [7:0] val
   );
      ctrl_three_next = {cur[ack_time_bit], val[6:0]};
   endfunction

   // Status byte: full, overflow and the registered idle level
   function automatic logic [7:0] status_byte(
      input logic f,
      input logic o,
      input logic i
   );
      logic [7:0] s;
      s = 8'h00;
      s[full_bit] = f;
      s[ovf_bit]  = o;
      s[idle_bit] = i;
      return s;
   endfunction

   rx_buffer_ctl #(
      .width(8)
   ) u_rx (
      .clk         (clk),
      .rst         (rst),
      .mode        (q.mode),
      .overwrite_en(q.ctrl_three[overwr_bit]),
      .byte_done   (byte_done),
      .byte_in     (byte_in),
      .buf_read    (buf_read),
      .ovf_clear   (ovf_clear),
      .sw_load     (sw_load),
      .sw_data     (q.w_data[7:0]),
      .buf_data    (buf_data),
      .full        (full),
      .ovf         (ovf)
   );

   always_comb begin
      logic wr;
      logic [7:0] wv;
      wr = 1'b0;
      wv = 8'h00;
      d = q;
      buf_read = 1'b0;
      ovf_clear = 1'b0;
      sw_load = 1'b0;
      d.tx_load = 1'b0;
      d.idle_s = engine_idle;
      // Hardware clears the requests when a sequence ends
      if (seq_done) begin
         d.ctrl_two[4:0] = 5'h00;
      end
      // Address and data may arrive in either order
      if (axi_req.awvalid && q.rsp.awready) begin
         d.aw_got = 1'b1;
         d.aw_addr = axi_req.awaddr;
         d.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && q.rsp.wready) begin
         d.w_got = 1'b1;
         d.w_data = axi_req.wdata;
         d.w_strb = axi_req.wstrb;
         d.rsp.wready = 1'b0;
      end

      // Write commit
      if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
         wr = q.w_strb[0];
         wv = q.w_data[7:0];
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = known(q.aw_addr) ? resp_okay : resp_slverr;
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         if (wr) begin
            unique case (q.aw_addr)
               ctrl_two_off:
                  d.ctrl_two = ctrl_two_next(d.ctrl_two, wv, engine_idle);
               ctrl_three_off:
                  d.ctrl_three = ctrl_three_next(q.ctrl_three, wv);
               buf_off: begin
                  if (engine_idle) begin
                     sw_load = 1'b1;
                     d.tx_load = 1'b1;
                  end
               end
               stat_off: ovf_clear = !wv[ovf_bit];
               mode_off: d.mode = port_mode_e'(wv[1:0]);
               default: ;
            endcase
         end
      end

      // Write response
      if (q.rsp.bvalid && axi_req.bready) begin
         d.rsp.bvalid = 1'b0;
         d.rsp.awready = 1'b1;
         d.rsp.wready = 1'b1;
      end

      // Read channel
      if (axi_req.arvalid && q.rsp.arready) begin
         d.rsp.arready = 1'b0;
         d.rsp.rvalid = 1'b1;
         d.rsp.rresp = known(axi_req.araddr) ? resp_okay : resp_slverr;
         d.rsp.rdata = 32'h0000_0000;
         unique case (axi_req.araddr)
            ctrl_two_off:   d.rsp.rdata[7:0] = q.ctrl_two;
            ctrl_three_off: d.rsp.rdata[7:0] = q.ctrl_three;
            buf_off: begin
               d.rsp.rdata[7:0] = buf_data;
               buf_read = 1'b1;
            end
            stat_off: d.rsp.rdata[7:0] = status_byte(full, ovf, q.idle_s);
            mode_off: d.rsp.rdata[1:0] = q.mode;
            default: ;
         endcase
      end

      // Read response
      if (q.rsp.rvalid && axi_req.rready) begin
         d.rsp.rvalid = 1'b0;
         d.rsp.arready = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.ctrl_two <= ctrl_two_rst;
         q.ctrl_three <= ctrl_three_rst;
         q.mode <= mode_spi_master;
         q.rsp.awready <= 1'b1;
         q.rsp.wready <= 1'b1;
         q.rsp.arready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign axi_rsp      = q.rsp;
   assign seq_request  = q.ctrl_two[4:0];
   assign overwrite_en = q.ctrl_three[overwr_bit];
   assign port_mode    = q.mode;
   assign tx_data      = buf_data;
   assign tx_load      = q.tx_load;
endmodule

//--- tb/engine_model.sv
// Far-side model: serial engine that runs sequences and delivers bytes.
// Assumes the testbench calls send_byte just after a rising clock edge.
`timescale 1ns/100ps
module engine_model #(
   parameter int lat = 30
) (
   // Engine port
   input  wire logic       clk,
   input  wire logic [4:0] seq_request,
   output logic            engine_idle,
   output logic            byte_done,
   output logic [7:0]      byte_in,
   output logic            seq_done
);
   initial begin
      engine_idle = 1'b1;
      byte_done = 1'b0;
      byte_in = 8'h00;
      seq_done = 1'b0;
   end
   // Busy for lat+1 cycles per sequence, with the done pulse in the last busy cycle
   always @(posedge clk) begin
      if (|seq_request && engine_idle) begin
         engine_idle <= 1'b0;
         repeat (lat) @(posedge clk);
         seq_done <= 1'b1;
         @(posedge clk);
         seq_done <= 1'b0;
         engine_idle <= 1'b1;
      end
   end
   // One byte; data line shows the inverse once released
   task automatic send_byte(input logic [7:0] b);
      byte_done <= 1'b1;
      byte_in <= b;
      @(posedge clk);
      byte_done <= 1'b0;
      byte_in <= ~b;
      @(posedge clk);
   endtask
endmodule

//--- tb/sspc3_chk.sv
// Checker for the control three slice, bound to its top module.
// Assumes one clock and the top module's port names.
`timescale 1ns/100ps
module sspc3_chk
   import sspc3_pkg::*;
(
   // Watched ports
   input wire logic       clk,
   input wire logic       rst,
   input wire axil_req_s  axi_req,
   input wire axil_rsp_s  axi_rsp,
   input wire logic       engine_idle,
   input wire logic       byte_done,
   input wire logic [7:0] byte_in,
   input wire logic [4:0] seq_request,
   input wire logic       overwrite_en,
   input wire logic [1:0] port_mode,
   input wire logic [7:0] tx_data,
   input wire logic       tx_load
);
   logic full_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Tracks buffer full: set by a byte, cleared by a buffer read
   always_ff @(posedge clk) begin
      if (rst)
         full_q <= 1'b0;
      else if (byte_done)
         full_q <= 1'b1;
      else if (axi_req.arvalid && axi_rsp.arready && axi_req.araddr == buf_off)
         full_q <= 1'b0;
   end
   sequence s_busy;
      !engine_idle;
   endsequence
   sequence s_hold;
      byte_done && full_q && port_mode == 2'h1 && !overwrite_en;
   endsequence
   chk_no_spool: assert property (s_busy |=>
      (seq_request & ~$past(seq_request)) == 5'h00)
      else $error("request bit set while busy");
   chk_buf_locked: assert property (s_busy |=> !tx_load)
      else $error("buffer loaded while busy");
   chk_keep_full: assert property (s_hold |=> $stable(tx_data))
      else $error("full buffer overwritten");
   chk_master_take: assert property ((byte_done && !port_mode[0])
      |=> tx_data == $past(byte_in))
      else $error("master mode byte not taken");
   chk_overwrite_take: assert property ((byte_done && port_mode == 2'h1
      && overwrite_en) |=> tx_data == $past(byte_in))
      else $error("overwrite byte not taken");
endmodule

bind sync_serial_port_ctrl3 sspc3_chk chk_u (.clk, .rst, .axi_req, .axi_rsp,
   .engine_idle, .byte_done, .byte_in, .seq_request, .overwrite_en,
   .port_mode, .tx_data, .tx_load);

//--- tb/testbench.sv
// Testbench for the control three slice: bus tasks and scenarios.
// Assumes the engine model and checker are compiled before it.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench
   import sspc3_pkg::*;
;
   logic        clk, rst, engine_idle, byte_done, seq_done;
   logic        overwrite_en, tx_load;
   logic [7:0]  byte_in, tx_data;
   logic [4:0]  seq_request;
   logic [1:0]  port_mode, r;
   logic [31:0] d;
   axil_req_s   axi_req;
   axil_rsp_s   axi_rsp;
   int          mismatches = 0, n_tests = 0, cyc = 0, n_load = 0;

   sync_serial_port_ctrl3 dut_u (.clk, .rst, .axi_req, .axi_rsp,
      .engine_idle, .byte_done, .byte_in, .seq_done, .seq_request,
      .overwrite_en, .port_mode, .tx_data, .tx_load);
   engine_model eng_u (.clk, .seq_request, .engine_idle, .byte_done,
      .byte_in, .seq_done);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (tx_load) n_load++;
      if (cyc == 4000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= 32'(v);
      do begin
         @(posedge clk);
         if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (!axi_rsp.bvalid);
      r = axi_rsp.bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      do begin
         @(posedge clk);
         if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (!axi_rsp.rvalid);
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
   endtask

   task automatic t_regs;
      rd(ctrl_three_off);
      `CHK("ctl3 reset", 8'h00, d[7:0])
      rd(8'h14);
      `CHK("unmapped", resp_slverr, r)
      `CHK("unmapped data", 32'h0000_0000, d)
      wr(8'h14, 8'h00);
      `CHK("unmapped write", resp_slverr, r)
      wr(ctrl_three_off, 8'hFF);
      `CHK("write okay", resp_okay, r)
      `CHK("overwrite pin", 1'b1, overwrite_en)
      rd(ctrl_three_off);
      `CHK("ctl3 ro bit", 8'h7F, d[7:0])
      wr(ctrl_three_off, 8'h00);
      `CHK("overwrite pin", 1'b0, overwrite_en)
      $display("done regs");
   endtask
   task automatic t_busy;
      wr(mode_off, 8'h02);
      wr(ctrl_two_off, 8'h01);
      `CHK("request", 5'h01, seq_request)
      repeat (2) @(posedge clk);
      wr(ctrl_two_off, 8'h05);
      rd(ctrl_two_off);
      `CHK("stop refused", 8'h01, d[7:0])
      `CHK("request kept", 5'h01, seq_request)
      wr(buf_off, 8'hA5);
      `CHK("buf locked", 8'h00, tx_data)
      rd(stat_off);
      `CHK("busy flag", 1'b0, d[idle_bit])
      wait (engine_idle);
      @(posedge clk);
      rd(ctrl_two_off);
      `CHK("no spool", 8'h00, d[7:0])
      `CHK("request cleared", 5'h00, seq_request)
      wr(buf_off, 8'h3C);
      repeat (2) @(posedge clk);
      `CHK("buf write", 8'h3C, tx_data)
      `CHK("loads", 1, n_load)
      $display("done busy");
   endtask
   task automatic t_ovf;
      logic keep;
      for (int m = 0; m < 4; m++)
         for (int o = 0; o < 2; o++) begin
            keep = (m == 1 && o == 0) || m == 3;
            wr(mode_off, 8'(m));
            `CHK("mode pin", 2'(m), port_mode)
            wr(ctrl_three_off, 8'(o << 4));
            rd(ctrl_three_off);
            `CHK("ctl3", 8'(o << 4), d[7:0])
            rd(buf_off);
            wr(stat_off, 8'h00);
            eng_u.send_byte(8'h5A);
            eng_u.send_byte(8'hC3);
            `CHK("buffer", keep ? 8'h5A : 8'hC3, tx_data)
            rd(stat_off);
            `CHK("overflow", keep, d[ovf_bit])
         end
      $display("done overflow");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      axi_req = '0;
      axi_req.wstrb = 4'hF;
      axi_req.bready = 1'b1;
      axi_req.rready = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_busy();
      t_ovf();
      finish_test();
   end
endmodule
